// File: rtl/i2c_status_interrupt_logic.sv
// Serial bus status register and interrupt request logic
`timescale 1ns/100ps
`include "i2c_status_params.svh"

// What this block does
// - Status read-only except interrupt flag bit 5
// - Request needs engine on and both enables
// - Own address match in slave with ack sets flag
// - General call in slave with ack sets flag
// - Every master byte sets flag, even arbitration lost
// - Every selected-slave byte sets flag
// - Stop seen as selected slave sets flag
// - Selected only after own address matched
// - General call address zero in slave sets general call bit
// - Start or stop clears general call bit
// - Master with general call bit sets lost
// - Start sets busy, stop clears busy
// - Lost arbitration in master sets lost bit
// - Ack slot level after transmit gives nack bit
// - Slave bit shows slave mode, zero master
module i2c_status_interrupt_logic
  import i2c_status_pkg::*;
(
  // Core clock and reset
  input  wire logic       ref_clk_i,
  input  wire logic       resetn_i,
  // Link clock and bus pins
  input  wire logic       scl_clk_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  // Special function register access
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  // Engine state and settings
  input  wire logic       engine_enabled_i,
  input  wire logic       master_mode_i,
  input  wire logic       tx_mode_i,
  input  wire logic       ack_enable_i,
  input  wire logic       arb_lost_i,
  input  wire logic [6:0] own_slave_address_i,
  // Interrupt enables and request
  input  wire logic       serial_bus_irq_enable_i,
  input  wire logic       global_irq_enable_i,
  output logic            serial_irq_o
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  logic [7:0]  link_shift;
  logic        link_tgl;
  logic [2:0]  pin_sync;
  logic        scl_s;
  logic        sda_s;
  logic        tgl_s;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        tgl_prev_reg;
  logic        start_det;
  logic        stop_det;
  logic        bit_evt;
  logic        byte_evt;
  logic        ack_evt;
  logic        addr_evt;
  logic [6:0]  rx_addr;
  logic        own_hit;
  logic        gc_hit;
  logic        slave_mode;
  logic        irq_set;
  logic        sw_write;
  xfer_state_e xfer_reg;
  logic [3:0]  bit_cnt_reg;
  logic        selected_reg;
  logic        serial_irq_flag_reg;
  logic        general_call_seen_reg;
  logic        stop_seen_reg;
  logic        bus_in_use_reg;
  logic        arbitration_lost_reg;
  logic        no_ack_received_reg;
  logic        slave_role_reg;
  logic        tx_mode_reg;
  status_t     status;

  function automatic logic addr_equal(input logic [6:0] a, input logic [6:0] b);
    return a == b;
  endfunction

  // ---------------------------------------------------------------------------
  // Link domain and crossing
  // ---------------------------------------------------------------------------
  link_bit_shifter u_link (
    .scl_clk_i (scl_clk_i),
    .resetn_i  (resetn_i),
    .sda_i     (sda_i),
    .shift_o   (link_shift),
    .bit_tgl_o (link_tgl)
  );

  bit_sync #(.WIDTH(3)) u_sync (
    .ref_clk_i (ref_clk_i),
    .resetn_i  (resetn_i),
    .async_i   ({scl_i, sda_i, link_tgl}),
    .sync_o    (pin_sync)
  );

  assign scl_s = pin_sync[2];
  assign sda_s = pin_sync[1];
  assign tgl_s = pin_sync[0];

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      tgl_prev_reg <= 1'b0;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      tgl_prev_reg <= tgl_s;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus events
  // ---------------------------------------------------------------------------
  assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
  assign stop_det  = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;
  assign bit_evt   = (tgl_s != tgl_prev_reg) && (xfer_reg != XFER_IDLE);
  assign byte_evt  = bit_evt && (bit_cnt_reg == `LAST_DATA_BIT);
  assign ack_evt   = bit_evt && (bit_cnt_reg == `ACK_SLOT_BIT);
  assign addr_evt  = byte_evt && (xfer_reg == XFER_ADDR);
  assign rx_addr   = link_shift[7:1];
  assign slave_mode = !master_mode_i;
  assign own_hit   = addr_evt && slave_mode && addr_equal(rx_addr, own_slave_address_i);
  assign gc_hit    = addr_evt && slave_mode && addr_equal(rx_addr, `GENERAL_CALL_ADDR);

  // Bit counter and transfer phase
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      xfer_reg    <= XFER_IDLE;
      bit_cnt_reg <= 4'h0;
    end else if (start_det) begin
      xfer_reg    <= XFER_ADDR;
      bit_cnt_reg <= 4'h0;
    end else if (stop_det) begin
      xfer_reg    <= XFER_IDLE;
      bit_cnt_reg <= 4'h0;
    end else if (ack_evt) begin
      xfer_reg    <= XFER_DATA;
      bit_cnt_reg <= 4'h0;
    end else if (bit_evt) begin
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
    end
  end

  // Selected slave state
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      selected_reg <= 1'b0;
    end else if (own_hit) begin
      selected_reg <= 1'b1;
    end else if (start_det || stop_det) begin
      selected_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Interrupt flag
  // ---------------------------------------------------------------------------
  assign irq_set = engine_enabled_i && (
                   (own_hit && ack_enable_i) ||
                   (gc_hit && ack_enable_i) ||
                   (ack_evt && master_mode_i) ||
                   (ack_evt && selected_reg && slave_mode) ||
                   (stop_det && selected_reg));
  assign sw_write = sfr_wr_i && (sfr_addr_i == `STATUS_REG_ADDR);

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      serial_irq_flag_reg <= 1'b0;
    end else if (irq_set) begin
      serial_irq_flag_reg <= 1'b1;
    end else if (sw_write) begin
      serial_irq_flag_reg <= sfr_wdata_i[`IRQ_BIT];
    end
  end

  assign serial_irq_o = serial_irq_flag_reg && engine_enabled_i &&
                        serial_bus_irq_enable_i && global_irq_enable_i;

  // ---------------------------------------------------------------------------
  // Read-only status bits
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      general_call_seen_reg <= 1'b0;
    end else if (gc_hit) begin
      general_call_seen_reg <= 1'b1;
    end else if (start_det || stop_det) begin
      general_call_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stop_seen_reg <= 1'b0;
    end else if (stop_det) begin
      stop_seen_reg <= 1'b1;
    end else if (start_det) begin
      stop_seen_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_in_use_reg <= 1'b0;
    end else if (start_det) begin
      bus_in_use_reg <= 1'b1;
    end else if (stop_det) begin
      bus_in_use_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      arbitration_lost_reg <= 1'b0;
    end else if (master_mode_i && (arb_lost_i || general_call_seen_reg)) begin
      arbitration_lost_reg <= 1'b1;
    end else if (start_det) begin
      arbitration_lost_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      no_ack_received_reg <= 1'b0;
    end else if (ack_evt && tx_mode_i) begin
      no_ack_received_reg <= link_shift[0];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slave_role_reg <= 1'b0;
      tx_mode_reg    <= 1'b0;
    end else begin
      slave_role_reg <= slave_mode;
      tx_mode_reg    <= tx_mode_i;
    end
  end

  // ---------------------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------------------
  always_comb begin
    status = `STATUS_RESET;
    status[`GC_BIT]   = general_call_seen_reg;
    status[`STOP_BIT] = stop_seen_reg;
    status[`IRQ_BIT]  = serial_irq_flag_reg;
    status[`TX_BIT]   = tx_mode_reg;
    status[`BUSY_BIT] = bus_in_use_reg;
    status[`LOST_BIT] = arbitration_lost_reg;
    status[`NACK_BIT] = no_ack_received_reg;
    status[`SLV_BIT]  = slave_role_reg;
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sfr_rdata_o <= `STATUS_RESET;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= (sfr_addr_i == `STATUS_REG_ADDR) ? status : 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  sequence s_own_addr;
    addr_evt && slave_mode && ack_enable_i && engine_enabled_i &&
      addr_equal(rx_addr, own_slave_address_i);
  endsequence

  sequence s_flag_up;
    ##1 serial_irq_flag_reg;
  endsequence

  a_irq_gate_on: assert property (serial_irq_o |-> serial_irq_flag_reg && engine_enabled_i &&
                                  serial_bus_irq_enable_i && global_irq_enable_i)
    else $error("interrupt request without all enables");
  a_own_addr_flag: assert property (s_own_addr |-> s_flag_up)
    else $error("own address match did not set flag");
  a_gc_addr_flag: assert property (gc_hit && ack_enable_i && engine_enabled_i |=> serial_irq_flag_reg)
    else $error("general call did not set flag");
  a_master_byte_flag: assert property (ack_evt && master_mode_i && engine_enabled_i |-> s_flag_up)
    else $error("master byte did not set flag");
  a_sel_byte_flag: assert property (ack_evt && selected_reg && slave_mode && engine_enabled_i
                                    |=> serial_irq_flag_reg)
    else $error("selected slave byte did not set flag");
  a_sel_stop_flag: assert property (stop_det && selected_reg && engine_enabled_i |=> serial_irq_flag_reg)
    else $error("stop as selected slave did not set flag");
  a_select_cause: assert property ($rose(selected_reg) |-> $past(own_hit))
    else $error("selected without own address match");
  a_gc_bit_set: assert property (gc_hit |=> general_call_seen_reg ##1 general_call_seen_reg ||
                                 $past(start_det) || $past(stop_det))
    else $error("general call bit not held");
  a_gc_bit_clear: assert property ((start_det || stop_det) && !gc_hit |=> !general_call_seen_reg)
    else $error("general call bit not cleared by start or stop");
  a_lost_by_gc: assert property (master_mode_i && general_call_seen_reg |=> arbitration_lost_reg)
    else $error("lost bit not set with general call in master");
  a_busy_track: assert property (start_det |=> bus_in_use_reg [*1] ##0 !stop_seen_reg)
    else $error("busy not set after start");
  a_busy_free: assert property (stop_det && !start_det |=> !bus_in_use_reg)
    else $error("busy not cleared after stop");
  a_lost_by_arb: assert property (master_mode_i && arb_lost_i |=> arbitration_lost_reg)
    else $error("lost bit not set on arbitration loss");
  a_nack_level: assert property (ack_evt && tx_mode_i |=> no_ack_received_reg == $past(link_shift[0]))
    else $error("nack bit differs from ack slot level");
  a_slave_bit: assert property (##1 slave_role_reg == !$past(master_mode_i))
    else $error("slave bit does not follow mode");
  a_flag_clear: assert property (sw_write && !sfr_wdata_i[`IRQ_BIT] && !irq_set |=> !serial_irq_flag_reg)
    else $error("flag not cleared by write of zero");
  a_ro_bits_kept: assert property (sw_write && !start_det && !stop_det && !gc_hit
                                   |=> general_call_seen_reg == $past(general_call_seen_reg))
    else $error("write changed a read-only bit");

endmodule // i2c_status_interrupt_logic

// File: rtl/i2c_status_params.svh
// Constants of the serial bus status and interrupt logic
`ifndef I2C_STATUS_PARAMS_SVH
`define I2C_STATUS_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define STATUS_REG_ADDR      8'hdd
`define STATUS_RESET         8'h00

// ----------------------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------------------
`define GC_BIT               7
`define STOP_BIT             6
`define IRQ_BIT              5
`define TX_BIT               4
`define BUSY_BIT             3
`define LOST_BIT             2
`define NACK_BIT             1
`define SLV_BIT              0

// ----------------------------------------------------------------------------
// Bus values and bit counts
// ----------------------------------------------------------------------------
`define GENERAL_CALL_ADDR    7'h00
`define LAST_DATA_BIT        4'h7
`define ACK_SLOT_BIT         4'h8

`endif

// File: rtl/i2c_status_pkg.sv
// Types of the serial bus status and interrupt logic
package i2c_status_pkg;

  typedef enum logic [1:0] {
    XFER_IDLE = 2'b00,
    XFER_ADDR = 2'b01,
    XFER_DATA = 2'b10
  } xfer_state_e;

  typedef logic [7:0] status_t;

endpackage

// File: rtl/bit_sync.sv
// Two flip-flop synchroniser for independent levels
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             resetn_i,
  // Levels
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= '0;
      sync_o   <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end

endmodule // bit_sync

// File: rtl/link_bit_shifter.sv
// Link-side bit shifter clocked by the serial clock
`timescale 1ns/100ps
module link_bit_shifter (
  // Link clock and reset
  input  wire logic       scl_clk_i,
  input  wire logic       resetn_i,
  // Serial data
  input  wire logic       sda_i,
  // Captured bits
  output logic      [7:0] shift_o,
  output logic            bit_tgl_o
);

  // ---------------------------------------------------------------------------
  // Sample data on each rising clock edge
  // ---------------------------------------------------------------------------
  always_ff @(posedge scl_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_o <= 8'h00;
    end else begin
      shift_o <= {shift_o[6:0], sda_i};
    end
  end

  // Toggle marks one new bit for the core side
  always_ff @(posedge scl_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_tgl_o <= 1'b0;
    end else begin
      bit_tgl_o <= ~bit_tgl_o;
    end
  end

endmodule // link_bit_shifter

// File: bench/i2c_bus_model.sv
// Bus master model driving the serial clock and data lines
`timescale 1ns/100ps
module i2c_bus_model (
  // Bus lines
  output logic scl_o,
  output logic sda_o
);
  // ----------------------------------------------------------------------------
  // Idle lines at pull-up level, clock stands still outside frames
  // ----------------------------------------------------------------------------
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // ----------------------------------------------------------------------------
  // Conditions and bits, 64 ns clock period within frames
  // ----------------------------------------------------------------------------
  task automatic start_cond();
    sda_o = 1'b1;
    #16;
    scl_o = 1'b1;
    #32;
    sda_o = 1'b0;
    #32;
    scl_o = 1'b0;
    #16;
  endtask

  task automatic send_bit(input logic b);
    sda_o = b;
    #16;
    scl_o = 1'b1;
    #32;
    scl_o = 1'b0;
    #16;
  endtask

  task automatic send_byte(input logic [7:0] d, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      send_bit(d[i]);
    end
    send_bit(ack);
    // Released data line returns to pull-up level
    sda_o = 1'b1;
  endtask

  task automatic stop_cond();
    sda_o = 1'b0;
    #16;
    scl_o = 1'b1;
    #32;
    sda_o = 1'b1;
    #32;
  endtask
endmodule // i2c_bus_model

// File: bench/test_i2c_status_interrupt_logic.sv
// Self-checking bench of the serial bus status and interrupt logic
`timescale 1ns/100ps
`include "i2c_status_params.svh"
module test_i2c_status_interrupt_logic;
  // ----------------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------------
  logic       ref_clk     = 1'b0;
  logic       resetn      = 1'b0;
  logic [7:0] sfr_addr    = 8'h00;
  logic       sfr_wr      = 1'b0;
  logic       sfr_rd      = 1'b0;
  logic [7:0] sfr_wdata   = 8'h00;
  logic [7:0] sfr_rdata;
  logic       engine_en   = 1'b1;
  logic       master_mode = 1'b1;
  logic       tx_mode     = 1'b0;
  logic       ack_en      = 1'b1;
  logic       arb_lost    = 1'b0;
  logic [6:0] own_addr    = 7'h28;
  logic       irq_en      = 1'b1;
  logic       glob_en     = 1'b1;
  logic       serial_irq;
  logic       scl;
  logic       sda;
  logic [7:0] v;
  int         mismatches  = 0;
  int         checked     = 0;
  int         cycles      = 0;

  always #2.5 ref_clk = ~ref_clk;

  i2c_bus_model u_bus (
    .scl_o (scl),
    .sda_o (sda)
  );

  i2c_status_interrupt_logic u_dut (
    .ref_clk_i               (ref_clk),
    .resetn_i                (resetn),
    .scl_clk_i               (scl),
    .scl_i                   (scl),
    .sda_i                   (sda),
    .sfr_addr_i              (sfr_addr),
    .sfr_wr_i                (sfr_wr),
    .sfr_rd_i                (sfr_rd),
    .sfr_wdata_i             (sfr_wdata),
    .sfr_rdata_o             (sfr_rdata),
    .engine_enabled_i        (engine_en),
    .master_mode_i           (master_mode),
    .tx_mode_i               (tx_mode),
    .ack_enable_i            (ack_en),
    .arb_lost_i              (arb_lost),
    .own_slave_address_i     (own_addr),
    .serial_bus_irq_enable_i (irq_en),
    .global_irq_enable_i     (glob_en),
    .serial_irq_o            (serial_irq)
  );

  // ----------------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------------
  task automatic stop_test();
    $display("Counts: %0d checked, %0d mismatches", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge ref_clk);
    #1;
    sfr_wr = 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic sfr_read(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(posedge ref_clk);
    #1;
    sfr_rd = 1'b0;
    d      = sfr_rdata;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic status_is(input logic [7:0] exp);
    logic [7:0] s;
    sfr_read(`STATUS_REG_ADDR, s);
    check(s, exp);
  endtask

  task automatic settle();
    repeat (8) @(posedge ref_clk);
    #1;
  endtask

  // ----------------------------------------------------------------------------
  // Timeout
  // ----------------------------------------------------------------------------
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    status_is(8'h00);
    check({7'h00, serial_irq}, 8'h00);
    $display("Test reset done");

    sfr_write(`STATUS_REG_ADDR, 8'hff);
    status_is(8'h20);
    for (int i = 0; i < 4; i++) begin
      {engine_en, irq_en, glob_en} = 3'b111 ^ (3'b001 << i);
      @(posedge ref_clk);
      #1;
      check({7'h00, serial_irq}, {7'h00, i == 3});
    end
    irq_en = 1'b0;
    status_is(8'h20);
    irq_en = 1'b1;
    sfr_write(8'hde, 8'h00);
    status_is(8'h20);
    sfr_read(8'hde, v);
    check(v, 8'h00);
    sfr_write(`STATUS_REG_ADDR, 8'h00);
    status_is(8'h00);
    $display("Test register done");

    master_mode = 1'b0;
    u_bus.start_cond();
    settle();
    status_is(8'h09);
    u_bus.send_byte(8'h50, 1'b0);
    settle();
    status_is(8'h29);
    check({7'h00, serial_irq}, 8'h01);
    sfr_write(`STATUS_REG_ADDR, 8'h00);
    u_bus.send_byte(8'h3c, 1'b0);
    settle();
    status_is(8'h29);
    sfr_write(`STATUS_REG_ADDR, 8'h00);
    u_bus.stop_cond();
    settle();
    status_is(8'h61);
    sfr_write(`STATUS_REG_ADDR, 8'h00);
    $display("Test selected slave done");

    u_bus.start_cond();
    u_bus.send_byte(8'h52, 1'b0);
    u_bus.send_byte(8'h3c, 1'b0);
    settle();
    status_is(8'h09);
    u_bus.stop_cond();
    settle();
    status_is(8'h41);
    $display("Test other slave done");

    ack_en = 1'b0;
    u_bus.start_cond();
    u_bus.send_byte(8'h00, 1'b1);
    settle();
    status_is(8'h89);
    ack_en = 1'b1;
    u_bus.stop_cond();
    settle();
    status_is(8'h41);
    $display("Test no acknowledge done");

    u_bus.start_cond();
    u_bus.send_byte(8'h00, 1'b0);
    settle();
    status_is(8'ha9);
    master_mode = 1'b1;
    settle();
    status_is(8'hac);
    master_mode = 1'b0;
    sfr_write(`STATUS_REG_ADDR, 8'h00);
    u_bus.stop_cond();
    settle();
    status_is(8'h45);
    $display("Test general call done");

    master_mode = 1'b1;
    tx_mode     = 1'b1;
    u_bus.start_cond();
    settle();
    arb_lost = 1'b1;
    @(posedge ref_clk);
    #1;
    arb_lost = 1'b0;
    u_bus.send_byte(8'ha5, 1'b1);
    settle();
    status_is(8'h3e);
    sfr_write(`STATUS_REG_ADDR, 8'h00);
    u_bus.send_byte(8'h5a, 1'b0);
    settle();
    status_is(8'h3c);
    sfr_write(`STATUS_REG_ADDR, 8'h00);
    u_bus.stop_cond();
    settle();
    status_is(8'h54);
    $display("Test master done");
    stop_test();
  end
endmodule // test_i2c_status_interrupt_logic
